/* File: upds_regs.vh */
// register offsets, field positions and reset values for the descriptor select block
`ifndef UPDS_REGS_VH
`define UPDS_REGS_VH
// ****************************************************************
// apb register byte addresses
// ****************************************************************
`define UPDS_ADDR_CONFIG 12'h000
`define UPDS_ADDR_CONTROL 12'h004
`define UPDS_ADDR_XFER_STATUS 12'h008
`define UPDS_ADDR_POINTERS 12'h00C
`define UPDS_ADDR_LOOKUP 12'h010
`define UPDS_ADDR_BDT_BASE 12'h100
`define UPDS_ADDR_BDT_END 12'h500
// ****************************************************************
// config register fields
// ****************************************************************
`define UPDS_CFG_MODE_LSB 0
`define UPDS_CFG_ENABLE_BIT 2
`define UPDS_CFG_RESET 32'h0000_0000
// ****************************************************************
// buffering modes
// ****************************************************************
`define UPDS_MODE_NONE 2'h0
`define UPDS_MODE_EP0_OUT 2'h1
`define UPDS_MODE_ALL 2'h2
// ****************************************************************
// descriptor status byte fields
// ****************************************************************
`define UPDS_STAT_OWN_BIT 7
`define UPDS_STAT_TOGGLE_BIT 6
`define UPDS_STAT_TCHK_BIT 3
`define UPDS_STAT_STALL_BIT 2
`define UPDS_STAT_PID_LSB 2
// ****************************************************************
// table sizes
// ****************************************************************
`define UPDS_NUM_DESC 64
`define UPDS_NUM_EP 16
`endif

/* File: upds_desc_map.v */
// descriptor index mapper: endpoint, direction, parity and mode to index
`timescale 1ns/1ps
module upds_desc_map (
  input wire [1:0] mode_in,
  input wire [3:0] ep_in,
  input wire dir_in_in,
  input wire odd_in,
  output reg [5:0] index_out,
  output reg pingpong_out,
  output reg reserved_out
);
`include "upds_regs.vh"
  always @* begin
    pingpong_out = 1'b0;
    reserved_out = 1'b0;
    case (mode_in)
      `UPDS_MODE_NONE: begin
        index_out = {1'b0, ep_in, dir_in_in};
      end
      `UPDS_MODE_EP0_OUT: begin
        if (ep_in == 4'h0 && !dir_in_in) begin
          index_out = {5'h00, odd_in};
          pingpong_out = 1'b1;
        end else begin
          // odd toggle has no say on single-buffered slots
          index_out = {1'b0, ep_in, dir_in_in} + 6'h01;
        end
      end
      `UPDS_MODE_ALL: begin
        index_out = {ep_in, dir_in_in, odd_in};
        pingpong_out = 1'b1;
      end
      default: begin
        // reserved encoding falls back to single buffering
        index_out = {1'b0, ep_in, dir_in_in};
        reserved_out = 1'b1;
      end
    endcase
  end
endmodule // upds_desc_map

/* File: upds_pingpong_select.v */
// ping-pong pointer keeper and descriptor table with apb access
// ****************************************************************
// Summary of operation
// - three buffering modes via two-bit select
// - one even/odd pointer per endpoint
// - enabling module resets all pointers even
// - pointer flips on each completed transaction
// - last parity recorded in transfer status
// - pointer reset control clears all pointers
// - single and ep0-out mode index mapping
// - full ping-pong index mapping, endpoints 0-15
// - 64 descriptors, four bytes each
// - engine writes token pid into bits 5:2
// - toggle value ignored unless check enabled
// - descriptor bytes not cleared by reset
// - byte count ten bits, top two in status
// - status bit 7 marks engine ownership
// ****************************************************************
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module upds_pingpong_select (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire tok_valid_in,
  input wire [3:0] tok_ep_in,
  input wire tok_dir_in_in,
  input wire [3:0] tok_pid_in,
  input wire done_valid_in,
  input wire [9:0] done_count_in,
  output reg [5:0] sel_index_out,
  output reg sel_owned_out,
  output reg sel_stall_out,
  output reg sel_toggle_check_out,
  output reg sel_expected_toggle_out,
  output reg [9:0] sel_count_out,
  output reg [15:0] sel_addr_out
);
`include "upds_regs.vh"
  // ****************************************************************
  // state
  // ****************************************************************
  reg [7:0] stat_mem [0:`UPDS_NUM_DESC-1];
  reg [7:0] cnt_mem [0:`UPDS_NUM_DESC-1];
  reg [7:0] adrl_mem [0:`UPDS_NUM_DESC-1];
  reg [7:0] adrh_mem [0:`UPDS_NUM_DESC-1];
  reg [1:0] mode_ff;
  reg enable_ff;
  reg [15:0] ptr_ff;
  reg [3:0] last_ep_ff;
  reg last_dir_ff;
  reg last_parity_ff;
  reg last_valid_ff;
  reg busy_ff;
  reg [5:0] cur_idx_ff;
  reg [3:0] cur_ep_ff;
  reg cur_dir_ff;
  reg cur_odd_ff;
  reg [3:0] cur_pid_ff;
  reg [5:0] lookup_idx_ff;
  reg [3:0] lk_ep_ff;
  reg lk_dir_ff;
  reg lk_odd_ff;
  wire [5:0] map_idx;
  wire map_pp;
  wire map_rsv;
  wire [5:0] lk_idx;
  wire lk_pp;
  wire lk_rsv;
  wire acc;
  wire wr;
  wire bdt_hit;
  wire [5:0] bdt_idx;
  wire [1:0] bdt_byte;
  wire [11:0] bdt_off;
  reg [31:0] nxt_prdata;
  wire tok_odd;

  function ptr_bit;
    input [15:0] ptrs;
    input [3:0] ep;
    begin
      ptr_bit = ptrs[ep];
    end
  endfunction

  assign tok_odd = ptr_bit(ptr_ff, tok_ep_in);
  assign acc = psel_in & penable_in;
  assign wr = acc & pwrite_in;
  assign pready_out = 1'b1;
  // one aligned word per descriptor byte: descriptor n byte k at base + 16n + 4k
  assign bdt_off = paddr_in - `UPDS_ADDR_BDT_BASE;
  assign bdt_hit = (paddr_in >= `UPDS_ADDR_BDT_BASE) && (paddr_in < `UPDS_ADDR_BDT_END)
    && (paddr_in[1:0] == 2'h0);
  assign bdt_idx = bdt_off[9:4];
  assign bdt_byte = bdt_off[3:2];
  assign pslverr_out = 1'b0;

  // ****************************************************************
  // index mapping for live token and software lookup
  // ****************************************************************
  upds_desc_map u_map (
    .mode_in(mode_ff),
    .ep_in(tok_ep_in),
    .dir_in_in(tok_dir_in_in),
    .odd_in(tok_odd),
    .index_out(map_idx),
    .pingpong_out(map_pp),
    .reserved_out(map_rsv)
  );

  upds_desc_map u_lookup (
    .mode_in(mode_ff),
    .ep_in(lk_ep_ff),
    .dir_in_in(lk_dir_ff),
    .odd_in(lk_odd_ff),
    .index_out(lk_idx),
    .pingpong_out(lk_pp),
    .reserved_out(lk_rsv)
  );

  // ****************************************************************
  // control registers and pointers
  // ****************************************************************
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mode_ff <= `UPDS_MODE_NONE;
      enable_ff <= 1'b0;
      ptr_ff <= 16'h0000;
      last_ep_ff <= 4'h0;
      last_dir_ff <= 1'b0;
      last_parity_ff <= 1'b0;
      last_valid_ff <= 1'b0;
      lk_ep_ff <= 4'h0;
      lk_dir_ff <= 1'b0;
      lk_odd_ff <= 1'b0;
    end else begin
      if (wr && paddr_in == `UPDS_ADDR_CONFIG && pstrb_in[0]) begin
        mode_ff <= pwdata_in[`UPDS_CFG_MODE_LSB +: 2];
        enable_ff <= pwdata_in[`UPDS_CFG_ENABLE_BIT];
      end
      if (wr && paddr_in == `UPDS_ADDR_LOOKUP && pstrb_in[0]) begin
        lk_ep_ff <= pwdata_in[5:2];
        lk_dir_ff <= pwdata_in[1];
        lk_odd_ff <= pwdata_in[0];
      end
      if (wr && paddr_in == `UPDS_ADDR_XFER_STATUS && pstrb_in[0] && pwdata_in[0]) begin
        last_valid_ff <= 1'b0;
      end
      // a completion in the same cycle as a reset request does not flip the pointer: reset wins
      if (!enable_ff || (wr && paddr_in == `UPDS_ADDR_CONFIG && pstrb_in[0]
          && !pwdata_in[`UPDS_CFG_ENABLE_BIT])) begin
        ptr_ff <= 16'h0000;
      end else if (wr && paddr_in == `UPDS_ADDR_CONTROL && pstrb_in[0] && pwdata_in[0]) begin
        ptr_ff <= 16'h0000;
      end else if (busy_ff && done_valid_in) begin
        ptr_ff[cur_ep_ff] <= ~ptr_ff[cur_ep_ff];
      end
      if (busy_ff && done_valid_in && enable_ff) begin
        last_ep_ff <= cur_ep_ff;
        last_dir_ff <= cur_dir_ff;
        last_parity_ff <= cur_odd_ff;
        last_valid_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // transaction tracking and selected descriptor outputs
  // ****************************************************************
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      busy_ff <= 1'b0;
      cur_idx_ff <= 6'h00;
      cur_ep_ff <= 4'h0;
      cur_dir_ff <= 1'b0;
      cur_odd_ff <= 1'b0;
      cur_pid_ff <= 4'h0;
      sel_index_out <= 6'h00;
      sel_owned_out <= 1'b0;
      sel_stall_out <= 1'b0;
      sel_toggle_check_out <= 1'b0;
      sel_expected_toggle_out <= 1'b0;
      sel_count_out <= 10'h000;
      sel_addr_out <= 16'h0000;
    end else if (!enable_ff) begin
      busy_ff <= 1'b0;
    end else if (tok_valid_in && !busy_ff) begin
      // pointer only matters where the mode doubles this slot
      cur_idx_ff <= map_idx;
      cur_ep_ff <= tok_ep_in;
      cur_dir_ff <= tok_dir_in_in;
      cur_odd_ff <= map_pp ? tok_odd : 1'b0;
      cur_pid_ff <= tok_pid_in;
      busy_ff <= stat_mem[map_idx][`UPDS_STAT_OWN_BIT];
      sel_index_out <= map_idx;
      sel_owned_out <= stat_mem[map_idx][`UPDS_STAT_OWN_BIT];
      sel_stall_out <= stat_mem[map_idx][`UPDS_STAT_STALL_BIT];
      sel_toggle_check_out <= stat_mem[map_idx][`UPDS_STAT_TCHK_BIT];
      sel_expected_toggle_out <= stat_mem[map_idx][`UPDS_STAT_TCHK_BIT]
        & stat_mem[map_idx][`UPDS_STAT_TOGGLE_BIT];
      sel_count_out <= {stat_mem[map_idx][1:0], cnt_mem[map_idx]};
      sel_addr_out <= {adrh_mem[map_idx], adrl_mem[map_idx]};
    end else if (busy_ff && done_valid_in) begin
      busy_ff <= 1'b0;
      sel_owned_out <= 1'b0;
    end
  end

  // ****************************************************************
  // descriptor memories: no reset so contents stay undefined
  // ****************************************************************
  always @(posedge sys_clk_in) begin
    if (enable_ff && busy_ff && done_valid_in) begin
      // release: own clear, bit 6 kept, pid into 5:2, count top bits
      stat_mem[cur_idx_ff] <= {1'b0, stat_mem[cur_idx_ff][6], cur_pid_ff,
        done_count_in[9:8]};
      cnt_mem[cur_idx_ff] <= done_count_in[7:0];
    end else if (wr && bdt_hit) begin
      // engine-owned slots are written by software only at its own risk
      case (bdt_byte)
        2'h0: stat_mem[bdt_idx] <= pwdata_in[7:0];
        2'h1: cnt_mem[bdt_idx] <= pwdata_in[7:0];
        2'h2: adrl_mem[bdt_idx] <= pwdata_in[7:0];
        default: adrh_mem[bdt_idx] <= pwdata_in[7:0];
      endcase
    end
  end

  // ****************************************************************
  // apb read mux
  // ****************************************************************
  always @* begin
    nxt_prdata = 32'h0000_0000;
    if (bdt_hit) begin
      case (bdt_byte)
        2'h0: nxt_prdata = {24'h00_0000, stat_mem[bdt_idx]};
        2'h1: nxt_prdata = {24'h00_0000, cnt_mem[bdt_idx]};
        2'h2: nxt_prdata = {24'h00_0000, adrl_mem[bdt_idx]};
        default: nxt_prdata = {24'h00_0000, adrh_mem[bdt_idx]};
      endcase
    end else begin
      case (paddr_in)
        `UPDS_ADDR_CONFIG: nxt_prdata = {29'h0000_0000, enable_ff, mode_ff};
        `UPDS_ADDR_XFER_STATUS: nxt_prdata = {24'h00_0000, last_valid_ff,
          1'b0, last_ep_ff, last_dir_ff, last_parity_ff};
        `UPDS_ADDR_POINTERS: nxt_prdata = {16'h0000, ptr_ff};
        `UPDS_ADDR_LOOKUP: nxt_prdata = {22'h00_0000, lk_rsv, lk_pp,
          lk_idx, 2'h0};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= nxt_prdata;
    end
  end
endmodule // upds_pingpong_select

/* File: upds_chk.sv */
// port-level assertions for the descriptor select block
`timescale 1ns/1ps
module upds_chk (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire tok_valid_in,
  input wire [3:0] tok_ep_in,
  input wire tok_dir_in_in,
  input wire done_valid_in,
  input wire [5:0] sel_index_out,
  input wire sel_owned_out,
  input wire sel_toggle_check_out,
  input wire sel_expected_toggle_out
);
  reg en_ff;
  reg [1:0] mode_ff;
  // shadow of the config register, so index checks know the mode
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      en_ff <= 1'b0;
      mode_ff <= 2'h0;
    end else if (psel_in && penable_in && pwrite_in && paddr_in == 12'h000) begin
      en_ff <= pwdata_in[2];
      mode_ff <= pwdata_in[1:0];
    end
  end
  // busy follows ownership, so a token is taken only when not owned
  wire take = tok_valid_in && en_ff && !sel_owned_out;
  // ********
  // assertions
  // ********
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_apb_always_ready: assert property (pready_out && !pslverr_out)
    else $error("apb answer not ready or error");
  a_reset_idle: assert property ($fell(sys_rst_in) |-> sel_index_out == 6'h00 && !sel_owned_out)
    else $error("selection not idle after reset");
  a_map_none: assert property (take && mode_ff == 2'h0
    |=> sel_index_out == {1'b0, $past(tok_ep_in), $past(tok_dir_in_in)})
    else $error("index wrong without ping-pong");
  a_map_all: assert property (take && mode_ff == 2'h2
    |=> sel_index_out[5:1] == {$past(tok_ep_in), $past(tok_dir_in_in)})
    else $error("index wrong with full ping-pong");
  a_map_ep0_in: assert property (take && mode_ff == 2'h1 && tok_ep_in == 4'h0 && tok_dir_in_in
    |=> sel_index_out == 6'h02)
    else $error("endpoint 0 in index wrong");
  a_toggle_gated: assert property (sel_expected_toggle_out |-> sel_toggle_check_out)
    else $error("toggle value passed without check enable");
  a_done_release: assert property (sel_owned_out && done_valid_in && en_ff |=> !sel_owned_out)
    else $error("ownership not released at completion");
  a_sel_hold: assert property (!tok_valid_in |=> $stable(sel_index_out))
    else $error("index changed without token");
  a_unmapped_zero: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == 12'h020
    |=> prdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  c_take_all: cover property (take && mode_ff == 2'h2);
  c_take_none: cover property (take && mode_ff == 2'h0);
  c_release: cover property (sel_owned_out && done_valid_in);
endmodule // upds_chk

/* File: upds_host.sv */
// engine-side traffic model: token and completion strobes
`timescale 1ns/1ps
module upds_host (
  input wire sys_clk_in,
  output reg tok_valid_out,
  output reg [3:0] tok_ep_out,
  output reg tok_dir_in_out,
  output reg [3:0] tok_pid_out,
  output reg done_valid_out,
  output reg [9:0] done_count_out
);
  initial begin
    tok_valid_out = 1'b0;
    tok_ep_out = 4'h0;
    tok_dir_in_out = 1'b0;
    tok_pid_out = 4'h0;
    done_valid_out = 1'b0;
    done_count_out = 10'h000;
  end
  // idle endpoint, pid and count fields are inverted so stale values cannot look valid
  task token(input [3:0] ep, input dir, input [3:0] pid);
    begin
      tok_valid_out <= 1'b1;
      tok_ep_out <= ep;
      tok_dir_in_out <= dir;
      tok_pid_out <= pid;
      @(posedge sys_clk_in);
      tok_valid_out <= 1'b0;
      tok_ep_out <= ~ep;
      tok_pid_out <= ~pid;
    end
  endtask
  task done(input [9:0] cnt, input integer gap);
    begin
      repeat (gap) @(posedge sys_clk_in);
      done_valid_out <= 1'b1;
      done_count_out <= cnt;
      @(posedge sys_clk_in);
      done_valid_out <= 1'b0;
      done_count_out <= ~cnt;
    end
  endtask
endmodule // upds_host

/* File: tb.sv */
// self-checking bench for the descriptor select block
`timescale 1ns/1ps
module tb;
  reg sys_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
  reg [11:0] paddr_in;
  reg [31:0] pwdata_in;
  reg [3:0] pstrb_in;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, tok_valid_in, tok_dir_in_in, done_valid_in;
  wire [3:0] tok_ep_in, tok_pid_in;
  wire [9:0] done_count_in, sel_count_out;
  wire [5:0] sel_index_out;
  wire sel_owned_out, sel_stall_out, sel_toggle_check_out, sel_expected_toggle_out;
  wire [15:0] sel_addr_out;
  integer mismatches, n_compared;
  reg [31:0] rd;
  upds_pingpong_select u_dut (.*);
  upds_host u_host (.sys_clk_in(sys_clk_in), .tok_valid_out(tok_valid_in),
    .tok_ep_out(tok_ep_in), .tok_dir_in_out(tok_dir_in_in), .tok_pid_out(tok_pid_in),
    .done_valid_out(done_valid_in), .done_count_out(done_count_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // ********
  // shared tasks
  // ********
  task chk(input string what, input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // idle cycle at the end keeps back-to-back calls from double-driving psel
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      n = 0;
      @(posedge sys_clk_in);
      while (pready_out !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge sys_clk_in);
      end
      rd = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge sys_clk_in);
    end
  endtask
  function [5:0] exp_idx(input [1:0] m, input [3:0] ep, input d, input o);
    if (m == 2'h2) exp_idx = {ep, d, o};
    else if (m == 2'h1 && ep == 4'h0) exp_idx = d ? 6'h02 : {5'h00, o};
    else if (m == 2'h1) exp_idx = {1'b0, ep, 1'b0} + 6'h01 + {5'h00, d};
    else exp_idx = {1'b0, ep, d};
  endfunction
  task xfer(input [11:0] stat_addr);
    begin
      apb(1'b1, stat_addr, 32'h0000_0080);
      u_host.token(4'h5, 1'b0, 4'h1);
      u_host.done(10'h001, 1);
    end
  endtask
  // ********
  // scenarios
  // ********
  task t_map;
    integer m, e, k;
    reg [3:0] ep;
    begin
      for (m = 0; m < 4; m = m + 1) begin
        apb(1'b1, 12'h000, m);
        for (e = 0; e < 3; e = e + 1) begin
          ep = (e == 0) ? 4'h0 : (e == 1) ? 4'h1 : 4'hF;
          for (k = 0; k < 4; k = k + 1) begin
            apb(1'b1, 12'h010, {ep, k[1:0]});
            apb(1'b0, 12'h010, 32'h0000_0000);
            chk("lookup", rd[9:2], {m == 3, m == 2 || (m == 1 && ep == 4'h0 && k < 2),
              exp_idx(m[1:0], ep, k[1], k[0])});
          end
        end
      end
    end
  endtask
  task t_pingpong;
    begin
      apb(1'b1, 12'h000, 32'h0000_0006);
      apb(1'b1, 12'h240, 32'h0000_00C8);
      apb(1'b1, 12'h244, 32'h0000_0040);
      apb(1'b1, 12'h248, 32'h0000_0034);
      apb(1'b1, 12'h24C, 32'h0000_0012);
      apb(1'b1, 12'h250, 32'h0000_00C4);
      u_host.token(4'h5, 1'b0, 4'h1);
      @(posedge sys_clk_in);
      chk("index even", sel_index_out, 6'h14);
      chk("owned", sel_owned_out, 1'h1);
      chk("toggle", {sel_toggle_check_out, sel_expected_toggle_out}, 2'h3);
      chk("count", sel_count_out, 10'h040);
      chk("addr", sel_addr_out, 16'h1234);
      u_host.done(10'h2A5, 0);
      apb(1'b0, 12'h240, 32'h0000_0000);
      chk("status", rd[7:0], 8'h46);
      apb(1'b0, 12'h244, 32'h0000_0000);
      chk("count byte", rd[7:0], 8'hA5);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("xfer even", rd[7:0], 8'h94);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("pointers", rd[15:0], 16'h0020);
      u_host.token(4'h5, 1'b0, 4'h9);
      @(posedge sys_clk_in);
      chk("index odd", sel_index_out, 6'h15);
      chk("toggle off", sel_expected_toggle_out, 1'h0);
      chk("stall", sel_stall_out, 1'h1);
      u_host.done(10'h003, 3);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("xfer odd", rd[7:0], 8'h95);
      u_host.token(4'h5, 1'b0, 4'h1);
      @(posedge sys_clk_in);
      chk("index back", sel_index_out, 6'h14);
      chk("released", sel_owned_out, 1'h0);
    end
  endtask
  task t_resets;
    begin
      xfer(12'h240);
      apb(1'b1, 12'h004, 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("ptr clear", rd[15:0], 16'h0000);
      xfer(12'h240);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0006);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("ptr enable", rd[15:0], 16'h0000);
      // slot 7 is written for the endpoint 3 token; descriptor 63 is written only as a memory check
      apb(1'b1, 12'h170, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0004);
      u_host.token(4'h3, 1'b1, 4'h9);
      @(posedge sys_clk_in);
      chk("mode0 index", sel_index_out, 6'h07);
      apb(1'b1, 12'h000, 32'h0000_0005);
      u_host.token(4'h0, 1'b1, 4'h9);
      @(posedge sys_clk_in);
      chk("ep0 in index", sel_index_out, 6'h02);
      apb(1'b1, 12'h4FC, 32'h0000_005A);
      apb(1'b0, 12'h4FC, 32'h0000_0000);
      chk("last desc", rd[7:0], 8'h5A);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    mismatches = 0;
    n_compared = 0;
    sys_rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    pstrb_in = 4'hF;
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    t_map;
    t_pingpong;
    t_resets;
    test_done;
  end
  initial begin
    #(5000 * 50);
    mismatches = mismatches + 1;
    test_done;
  end
endmodule // tb
bind upds_pingpong_select upds_chk u_chk (.*);
